// file: hdl/bcc_pkg.sv
// bcc_pkg: constants, field layout and carrier structs of the bridge chip control register.
// assumes one 100 MHz core clock; every timer counts enable ticks made from it.
package bcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register placement and reset value
  localparam logic [7:0] BCC_OFS_CTRL = 8'h40;
  localparam logic [31:0] BCC_CTRL_RST = 32'h0920_0020;

  // field positions
  localparam int BCC_B_MALF = 11;
  localparam int BCC_B_RDCNT_LO = 12;
  localparam int BCC_B_FC_ONE = 15;
  localparam int BCC_B_RETRY_STS = 16;
  localparam int BCC_B_RETRY_LO = 17;
  localparam int BCC_B_DISC_DIS = 19;
  localparam int BCC_B_DISC_SHORT = 20;
  localparam int BCC_B_CRS_LO = 21;
  localparam int BCC_B_DLY_ORD = 23;
  localparam int BCC_B_CPL_LO = 24;
  localparam int BCC_B_ISO_EN = 26;
  localparam int BCC_B_TC_LO = 27;
  localparam int BCC_B_PWR_SAVE = 30;
  localparam int BCC_B_LOCKOUT = 31;
  localparam int BCC_B_PF_MULT = 4;
  localparam int BCC_B_PF_LINE = 6;
  localparam int BCC_B_PF_READ = 8;

  // codes
  localparam logic [1:0] BCC_PF_FULL = 2'b10;
  localparam logic [1:0] BCC_CPL_OFF = 2'b11;
  localparam logic [2:0] BCC_TC_ZERO = 3'h0;

  // read byte counts
  localparam logic [12:0] BCC_RD_128 = 13'h0080;
  localparam logic [12:0] BCC_RD_256 = 13'h0100;
  localparam logic [12:0] BCC_RD_512 = 13'h0200;
  localparam logic [12:0] BCC_RD_1K = 13'h0400;
  localparam logic [12:0] BCC_RD_2K = 13'h0800;
  localparam logic [12:0] BCC_RD_4K = 13'h1000;

  // retry limits (in retries)
  localparam int BCC_RETRY_256 = 256;
  localparam int BCC_RETRY_64K = 65536;
  localparam longint BCC_RETRY_2G = 64'h0000_0000_8000_0000;

  // timing
  localparam int BCC_CLK_PERIOD_NS = 10;
  localparam int BCC_US_NS = 1000;
  localparam int BCC_CYC_PER_US = BCC_US_NS / BCC_CLK_PERIOD_NS;
  localparam int BCC_DISC_SHORT_PCLK = 64;
  localparam int BCC_CRS_25US = 25;
  localparam int BCC_CRS_05MS_US = 500;
  localparam int BCC_CPL_50US = 50;

  ////////////////////////////////////////////////////////////////////////////
  // configuration access carriers
  typedef struct packed {
    logic req;
    logic wr;
    logic prim;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bcc_cfg_req_s;

  typedef struct packed {
    logic ack;
    logic crs;
    logic [31:0] rdata;
  } bcc_cfg_rsp_s;

  typedef enum logic [1:0] {
    BCC_T_IDLE = 2'b00,
    BCC_T_RUN = 2'b01,
    BCC_T_DONE = 2'b11
  } bcc_tmr_e;

endpackage : bcc_pkg

// file: hdl/bcc_timeout.sv
// bcc_timeout: tick-driven timeout counter with start, stop and enable.
// assumes i_tick is a one-cycle enable pulse and i_limit is held while running.
`timescale 1ns/1ps
`default_nettype none
module bcc_timeout #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_enable,
  input wire logic [W-1:0] i_limit,
  // status
  output logic o_busy,
  output logic o_expired
);
  import bcc_pkg::*;

  bcc_tmr_e state_reg;
  logic [W-1:0] cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // state and count
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !i_enable || i_stop) begin
      state_reg <= BCC_T_IDLE;
      cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        BCC_T_IDLE: begin
          cnt_reg <= '0;
          if (i_start) begin
            state_reg <= BCC_T_RUN;
          end
        end
        BCC_T_RUN: begin
          if (i_tick) begin
            cnt_reg <= cnt_reg + W'(1);
            if (cnt_reg + W'(1) >= i_limit) begin
              state_reg <= BCC_T_DONE;
            end
          end
        end
        BCC_T_DONE: begin
          state_reg <= BCC_T_IDLE;
        end
        default: begin
          state_reg <= BCC_T_IDLE;
        end
      endcase
    end
  end

  // one-cycle expiry pulse in the done state
  assign o_expired = (state_reg == BCC_T_DONE);
  assign o_busy = (state_reg == BCC_T_RUN);

endmodule : bcc_timeout
`default_nettype wire

// file: hdl/bcc_chip_ctrl.sv
// bcc_chip_ctrl: chip control register of the bridge and the logic it steers.
// assumes config accesses arrive one at a time on a synchronous port from either side.
// What this block does
// RQ1 - bit 11 set enables optional malformed packet checks; reset clears it.
// RQ2 - field 14:12 maps to 128..4096 byte read cap; 000, 011, 111 give 512.
// RQ3 - read cap applies only when all three prefetch fields select full prefetch.
// RQ4 - bit 15 low updates flow control per two freed credits, high per one.
// RQ5 - retry expiry sets sticky status bit 16, held until cleared or reset.
// RQ6 - writing one to status bit 16 clears it; zero leaves it.
// RQ7 - field 18:17 sets retry limit: none, 256, 64K or 2G retries.
// RQ8 - bit 19 disables the discard timer, and so does the bridge control bit on its own.
// RQ9 - bit 20 set makes discard expire after 64 PCI clocks, else bridge bit 24.
// RQ10 - field 22:21 selects config retry timer: 25us, 0.5ms, 5ms, 25ms.
// RQ11 - bit 23 set forbids out-of-order completion of delayed transactions.
// RQ12 - field 25:24 selects completion timeout 50us, 10ms, 50ms or disabled.
// RQ13 - bit 26 low maps upstream memory traffic to TC0, else to field tc.
// RQ14 - traffic class field 29:27 resets to 001.
// RQ15 - bit 30 gates core clocks while the link sits in L1.
// RQ16 - bit 31 locks out primary config access with CRS completions.
// RQ17 - prefetch code 10 means full prefetch for prefetchable read addresses.
`timescale 1ns/1ps
`default_nettype none
module bcc_chip_ctrl #(
  parameter int PCI_DIV = 3,
  parameter int DISC_LONG_PCLK = 32768,
  parameter int DISC_MED_PCLK = 1024,
  parameter int CRS_5MS_US = 5000,
  parameter int CRS_25MS_US = 25000,
  parameter int CPL_10MS_US = 10000,
  parameter int CPL_50MS_US = 50000,
  parameter int RETRY_64K = bcc_pkg::BCC_RETRY_64K,
  parameter longint RETRY_2G = bcc_pkg::BCC_RETRY_2G
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // configuration access
  input wire bcc_pkg::bcc_cfg_req_s i_cfg,
  output bcc_pkg::bcc_cfg_rsp_s o_cfg,
  // read request sizing
  input wire logic i_rd_prefetchable,
  output logic o_rd_cap_en,
  output logic [12:0] o_rd_cap_bytes,
  // flow control
  input wire logic i_fc_credit_free,
  output logic o_fc_update,
  // pci retry counter
  input wire logic i_pci_retry,
  input wire logic i_pci_retry_clr,
  output logic o_retry_expired,
  // discard timer
  input wire logic i_brctl_disc_dis,
  input wire logic i_brctl_disc_short,
  input wire logic i_disc_start,
  input wire logic i_disc_stop,
  output logic o_disc_expired,
  // config retry and completion timers
  input wire logic i_crs_start,
  input wire logic i_crs_stop,
  output logic o_crs_expired,
  input wire logic i_cpl_start,
  input wire logic i_cpl_stop,
  output logic o_cpl_timeout,
  // mode outputs
  input wire logic i_link_l1,
  output logic o_malf_chk_en,
  output logic o_dly_in_order,
  output logic [2:0] o_tlp_tc,
  output logic o_clk_gate
);
  import bcc_pkg::*;

  logic [31:0] ctrl_reg;
  logic [30:0] rw_reg;
  logic retry_sts_reg;
  logic [31:0] wmask;
  logic hit;
  logic wr_ok;
  logic lock_hit;
  logic clr16;
  logic retry_hit;
  logic [31:0] retry_cnt_reg;
  logic [31:0] retry_lim;
  logic fc_cnt_reg;
  logic [7:0] us_cnt_reg;
  logic us_tick;
  logic [7:0] pci_cnt_reg;
  logic pci_tick;
  logic disc_en;
  logic [31:0] disc_lim;
  logic [31:0] crs_lim;
  logic [31:0] cpl_lim;
  logic pf_full;

  ////////////////////////////////////////////////////////////////////////////
  // access decode
  assign hit = i_cfg.req && (i_cfg.addr == BCC_OFS_CTRL);
  assign lock_hit = i_cfg.req && i_cfg.prim && ctrl_reg[BCC_B_LOCKOUT]; // RQ16
  assign wr_ok = hit && i_cfg.wr && !lock_hit;
  assign wmask = {{8{i_cfg.be[3]}}, {8{i_cfg.be[2]}}, {8{i_cfg.be[1]}}, {8{i_cfg.be[0]}}};
  assign clr16 = wr_ok && i_cfg.be[2] && i_cfg.wdata[BCC_B_RETRY_STS];
  assign ctrl_reg = {rw_reg[30:16], retry_sts_reg, rw_reg[15:0]}; // one driver per bit

  // plain read/write bits, status bit 16 kept apart
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rw_reg <= {BCC_CTRL_RST[31:17], BCC_CTRL_RST[15:0]}; // RQ14
    end else if (wr_ok) begin
      rw_reg <= (rw_reg & ~{wmask[31:17], wmask[15:0]}) |
                ({i_cfg.wdata[31:17], i_cfg.wdata[15:0]} & {wmask[31:17], wmask[15:0]});
    end
  end

  // sticky retry status, set wins over clear
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      retry_sts_reg <= BCC_CTRL_RST[BCC_B_RETRY_STS];
    end else if (retry_hit) begin
      retry_sts_reg <= 1'b1; // RQ5
    end else if (clr16) begin
      retry_sts_reg <= 1'b0; // RQ6
    end
  end

  // response: crs for locked primary, zero for unmapped
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_cfg <= '0;
    end else begin
      o_cfg.ack <= i_cfg.req;
      o_cfg.crs <= lock_hit; // RQ16
      o_cfg.rdata <= (hit && !i_cfg.wr && !lock_hit) ? ctrl_reg : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tick dividers: microseconds and pci clocks
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || us_tick) begin
      us_cnt_reg <= 8'h00;
    end else begin
      us_cnt_reg <= us_cnt_reg + 8'h01;
    end
  end
  assign us_tick = (us_cnt_reg == 8'(BCC_CYC_PER_US - 1));

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || pci_tick) begin
      pci_cnt_reg <= 8'h00;
    end else begin
      pci_cnt_reg <= pci_cnt_reg + 8'h01;
    end
  end
  assign pci_tick = (pci_cnt_reg == 8'(PCI_DIV - 1));

  ////////////////////////////////////////////////////////////////////////////
  // read cap: only when every prefetch field selects full prefetch
  assign pf_full = (ctrl_reg[BCC_B_PF_READ+:2] == BCC_PF_FULL) &&
                   (ctrl_reg[BCC_B_PF_LINE+:2] == BCC_PF_FULL) &&
                   (ctrl_reg[BCC_B_PF_MULT+:2] == BCC_PF_FULL); // RQ17

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rd_cap_en <= 1'b0;
      o_rd_cap_bytes <= BCC_RD_512;
    end else begin
      o_rd_cap_en <= pf_full && i_rd_prefetchable; // RQ3
      unique case (ctrl_reg[BCC_B_RDCNT_LO+:3]) // RQ2
        3'b001: o_rd_cap_bytes <= BCC_RD_128;
        3'b010: o_rd_cap_bytes <= BCC_RD_256;
        3'b100: o_rd_cap_bytes <= BCC_RD_1K;
        3'b101: o_rd_cap_bytes <= BCC_RD_2K;
        3'b110: o_rd_cap_bytes <= BCC_RD_4K;
        default: o_rd_cap_bytes <= BCC_RD_512;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flow control update per one or two freed credits
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      fc_cnt_reg <= 1'b0;
      o_fc_update <= 1'b0;
    end else begin
      o_fc_update <= 1'b0;
      if (i_fc_credit_free) begin
        if (ctrl_reg[BCC_B_FC_ONE] || fc_cnt_reg) begin
          o_fc_update <= 1'b1; // RQ4
          fc_cnt_reg <= 1'b0;
        end else begin
          fc_cnt_reg <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pci retry counter
  always_comb begin
    unique case (ctrl_reg[BCC_B_RETRY_LO+:2]) // RQ7
      2'b01: retry_lim = 32'(BCC_RETRY_256);
      2'b10: retry_lim = 32'(RETRY_64K);
      2'b11: retry_lim = 32'(RETRY_2G);
      default: retry_lim = 32'h0000_0000;
    endcase
  end
  assign retry_hit = i_pci_retry && (retry_lim != 32'h0000_0000) && (retry_cnt_reg + 32'h0000_0001 >= retry_lim);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_pci_retry_clr) begin
      retry_cnt_reg <= 32'h0000_0000;
      o_retry_expired <= 1'b0;
    end else begin
      o_retry_expired <= retry_hit;
      if (retry_hit) begin
        retry_cnt_reg <= 32'h0000_0000;
      end else if (i_pci_retry) begin
        retry_cnt_reg <= retry_cnt_reg + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer limits
  assign disc_en = !ctrl_reg[BCC_B_DISC_DIS] && !i_brctl_disc_dis; // RQ8
  assign disc_lim = ctrl_reg[BCC_B_DISC_SHORT] ? 32'(BCC_DISC_SHORT_PCLK) :
                    (i_brctl_disc_short ? 32'(DISC_MED_PCLK) : 32'(DISC_LONG_PCLK)); // RQ9

  always_comb begin
    unique case (ctrl_reg[BCC_B_CRS_LO+:2]) // RQ10
      2'b00: crs_lim = 32'(BCC_CRS_25US);
      2'b01: crs_lim = 32'(BCC_CRS_05MS_US);
      2'b10: crs_lim = 32'(CRS_5MS_US);
      default: crs_lim = 32'(CRS_25MS_US);
    endcase
    unique case (ctrl_reg[BCC_B_CPL_LO+:2]) // RQ12
      2'b00: cpl_lim = 32'(BCC_CPL_50US);
      2'b01: cpl_lim = 32'(CPL_10MS_US);
      default: cpl_lim = 32'(CPL_50MS_US);
    endcase
  end

  // discard timer counts pci clocks
  bcc_timeout #(.W(32)) u_disc (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_tick(pci_tick),
    .i_start(i_disc_start),
    .i_stop(i_disc_stop),
    .i_enable(disc_en),
    .i_limit(disc_lim),
    .o_busy(),
    .o_expired(o_disc_expired)
  );

  // config request retry timer counts microseconds
  bcc_timeout #(.W(32)) u_crs (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_tick(us_tick),
    .i_start(i_crs_start),
    .i_stop(i_crs_stop),
    .i_enable(1'b1),
    .i_limit(crs_lim),
    .o_busy(),
    .o_expired(o_crs_expired)
  );

  // completion timer, code 11 holds it idle
  bcc_timeout #(.W(32)) u_cpl (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_tick(us_tick),
    .i_start(i_cpl_start),
    .i_stop(i_cpl_stop),
    .i_enable(ctrl_reg[BCC_B_CPL_LO+:2] != BCC_CPL_OFF), // RQ12
    .i_limit(cpl_lim),
    .o_busy(),
    .o_expired(o_cpl_timeout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode outputs
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_malf_chk_en <= 1'b0;
      o_dly_in_order <= 1'b0;
      o_tlp_tc <= BCC_TC_ZERO;
      o_clk_gate <= 1'b0;
    end else begin
      o_malf_chk_en <= ctrl_reg[BCC_B_MALF]; // RQ1
      o_dly_in_order <= ctrl_reg[BCC_B_DLY_ORD]; // RQ11
      o_tlp_tc <= ctrl_reg[BCC_B_ISO_EN] ? ctrl_reg[BCC_B_TC_LO+:3] : BCC_TC_ZERO; // RQ13
      o_clk_gate <= ctrl_reg[BCC_B_PWR_SAVE] && i_link_l1; // RQ15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_retry_set_wins: assert property (retry_hit |=> ctrl_reg[BCC_B_RETRY_STS]) // RQ5
    else $error("retry status not set on expiry");
  a_rw1c_clear: assert property (clr16 && !retry_hit |=> !ctrl_reg[BCC_B_RETRY_STS]) // RQ6
    else $error("retry status not cleared by write one");
  a_retry_hold: assert property (ctrl_reg[BCC_B_RETRY_STS] && !clr16 |=> ctrl_reg[BCC_B_RETRY_STS]) // RQ5
    else $error("retry status dropped without clear");
  a_lockout_crs: assert property (i_cfg.req && i_cfg.prim && ctrl_reg[BCC_B_LOCKOUT]
                                  |=> o_cfg.ack && o_cfg.crs && o_cfg.rdata == 32'h0000_0000) // RQ16
    else $error("locked primary access not answered with crs");
  a_lockout_nowr: assert property (i_cfg.req && i_cfg.prim && ctrl_reg[BCC_B_LOCKOUT]
                                   && !retry_hit |=> $stable(ctrl_reg)) // RQ16
    else $error("locked primary write changed register");
  a_fc_pairing: assert property (!ctrl_reg[BCC_B_FC_ONE] && i_fc_credit_free && !fc_cnt_reg
                                 |=> !o_fc_update) // RQ4
    else $error("flow control update after single credit");
  a_rd_cap_gate: assert property (o_rd_cap_en |-> $past(pf_full)) // RQ3
    else $error("read cap applied without full prefetch");
  a_tc_zero: assert property (!ctrl_reg[BCC_B_ISO_EN] [*2] |-> o_tlp_tc == BCC_TC_ZERO) // RQ13
    else $error("traffic class not zero with iso off");
  a_cpl_off: assert property ((ctrl_reg[BCC_B_CPL_LO+:2] == BCC_CPL_OFF) [*2] |-> !o_cpl_timeout) // RQ12
    else $error("completion timeout while disabled");
  a_disc_off: assert property (!disc_en [*2] |-> !o_disc_expired) // RQ8
    else $error("discard expiry while disabled");
  a_clk_gate: assert property (ctrl_reg[BCC_B_PWR_SAVE] && i_link_l1 |=> o_clk_gate) // RQ15
    else $error("clock not gated in l1");

  c_cfg_write: cover property (wr_ok);
  c_retry_expire: cover property (retry_hit);
  c_lockout: cover property (lock_hit);
  c_crs_expire: cover property (o_crs_expired);

endmodule : bcc_chip_ctrl
`default_nettype wire

// file: testbench/bcc_cfg_host.sv
// bcc_cfg_host: configuration software model driving the config port.
// assumes one access per rising edge, answered one cycle later.
`timescale 1ns/1ps
`default_nettype none
module bcc_cfg_host (
  // clock
  input wire logic i_core_clk,
  // config port
  input wire bcc_pkg::bcc_cfg_rsp_s i_rsp,
  output var bcc_pkg::bcc_cfg_req_s o_req
);
  import bcc_pkg::*;

  // port idle at start
  initial o_req = '0;

  // drive on the falling edge, taken on the rising edge, answer read a half cycle later
  task automatic access(input logic wr, input logic prim, input logic [7:0] a, input logic [31:0] w,
                        output bcc_cfg_rsp_s rsp);
    @(negedge i_core_clk);
    o_req = '{1'b1, wr, prim, a, 4'hf, w};
    @(negedge i_core_clk);
    rsp = i_rsp;
    // released lines carry the inverse of the last value, never a stale copy
    o_req = '{1'b0, ~wr, ~prim, ~a, 4'h0, ~w};
  endtask : access
endmodule : bcc_cfg_host
`default_nettype wire

// file: testbench/bcc_chip_ctrl_tb_top.sv
// bcc_chip_ctrl_tb_top: self-checking bench for the chip control register.
// assumes the host model and the design share one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module bcc_chip_ctrl_tb_top;
  import bcc_pkg::*;
  ////////////////////////////////////////
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  bcc_cfg_req_s cfg;
  bcc_cfg_rsp_s rsp, s;
  logic pf = 1'b0, fc_free = 1'b0, retry = 1'b0, l1 = 1'b0, bdis = 1'b0;
  logic disc_go = 1'b0, crs_go = 1'b0, cpl_go = 1'b0;
  logic bshort = 1'b0, rclr = 1'b0, dstop = 1'b0, cstop = 1'b0, pstop = 1'b0;
  logic cap_en, fc_upd, r_exp, d_exp, c_exp, p_exp, malf, dly, gate;
  logic [12:0] cap;
  logic [2:0] tc;
  logic [31:0] v, r;
  integer seed = 32'hf8ad_b4d5;
  int err_count = 0, n_checks = 0, fc_n = 0, rx_n = 0, xp_n = 0, n;
  int crs_l[4] = '{25, 500, 3, 4};
  int cpl_l[4] = '{50, 3, 4, 0};
  int rl[4] = '{300, 256, 8, 16};

  // design with long counts shortened
  bcc_chip_ctrl #(.PCI_DIV(1), .DISC_LONG_PCLK(8), .DISC_MED_PCLK(4), .CRS_5MS_US(3), .CRS_25MS_US(4),
    .CPL_10MS_US(3), .CPL_50MS_US(4), .RETRY_64K(8), .RETRY_2G(16)) u_bcc_chip_ctrl (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_cfg(cfg), .o_cfg(rsp), .i_rd_prefetchable(pf),
    .o_rd_cap_en(cap_en), .o_rd_cap_bytes(cap), .i_fc_credit_free(fc_free), .o_fc_update(fc_upd),
    .i_pci_retry(retry), .i_pci_retry_clr(rclr), .o_retry_expired(r_exp), .i_brctl_disc_dis(bdis),
    .i_brctl_disc_short(bshort), .i_disc_start(disc_go), .i_disc_stop(dstop), .o_disc_expired(d_exp),
    .i_crs_start(crs_go), .i_crs_stop(cstop), .o_crs_expired(c_exp), .i_cpl_start(cpl_go),
    .i_cpl_stop(pstop), .o_cpl_timeout(p_exp), .i_link_l1(l1), .o_malf_chk_en(malf),
    .o_dly_in_order(dly), .o_tlp_tc(tc), .o_clk_gate(gate));

  // configuration software
  bcc_cfg_host u_bcc_cfg_host (.i_core_clk(clk), .i_rsp(rsp), .o_req(cfg));

  // clock
  always #5 clk = ~clk;

  // pulse counters, sampled where outputs are settled
  always @(negedge clk) begin
    if (fc_upd === 1'b1) fc_n++;
    if (r_exp === 1'b1) rx_n++;
    if (c_exp === 1'b1 || p_exp === 1'b1 || d_exp === 1'b1) xp_n++;
  end

  ////////////////////////////////////////
  // compare tasks and expectations
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  function automatic logic [12:0] cap_of(input logic [2:0] c);
    case (c)
      3'h1: return BCC_RD_128;
      3'h2: return BCC_RD_256;
      3'h4: return BCC_RD_1K;
      3'h5: return BCC_RD_2K;
      3'h6: return BCC_RD_4K;
      default: return BCC_RD_512;
    endcase
  endfunction : cap_of

  task automatic io(input logic wr, input logic prim, input logic [7:0] a, input logic [31:0] w);
    u_bcc_cfg_host.access(wr, prim, a, w, s);
    r = s.rdata;
  endtask : io

  // one-cycle pulse on a selected event input
  task automatic pulse(input int k);
    @(negedge clk);
    case (k)
      0: fc_free = 1'b1;
      1: retry = 1'b1;
      2: disc_go = 1'b1;
      3: crs_go = 1'b1;
      4: cpl_go = 1'b1;
      5: rclr = 1'b1;
      default: {dstop, cstop, pstop} = 3'b111;
    endcase
    @(negedge clk);
    {fc_free, retry, disc_go, crs_go, cpl_go, rclr, dstop, cstop, pstop} = 9'h000;
  endtask : pulse

  // start a timer and count cycles to its expiry; lim 0 means it must stay silent
  task automatic time_it(input int k, input int lim, input int per);
    int top;
    top = lim ? lim * per + 10 : 3000;
    pulse(k + 2);
    n = 0;
    while (n < top && (k == 0 ? d_exp : k == 1 ? c_exp : p_exp) !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    if (lim == 0) chk_rng(n, top, top);
    else chk_rng(n, (lim - 1) * per, lim * per + 3);
  endtask : time_it

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////
  // watchdog: the tests take about 75k cycles, cut off at 100k
  initial begin
    #1_000_000;
    err_count++;
    stop_test();
  end

  // main sequence
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    io(1'b0, 1'b0, BCC_OFS_CTRL, 32'h0);
    chk(r, BCC_CTRL_RST);
    chk({16'h0, tc, cap}, {16'h0, 3'h0, BCC_RD_512});
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      v[31] = 1'b0;
      v[14:12] = i[2:0];
      if (i[3]) v[9:4] = 6'b10_1010;
      pf = 1'($random(seed));
      l1 = 1'($random(seed));
      io(1'b1, 1'b0, BCC_OFS_CTRL, v);
      io(1'b0, 1'b0, BCC_OFS_CTRL, 32'h0);
      chk(r, v & 32'hfffe_ffff);
      chk({18'h0, cap_en, cap}, {18'h0, pf & (v[9:4] == 6'b10_1010), cap_of(v[14:12])});
      chk({26'h0, malf, dly, tc, gate}, {26'h0, v[11], v[23], v[26] ? v[29:27] : 3'h0, v[30] & l1});
    end
    $display("test modes done");
    for (int b = 0; b < 2; b++) begin
      io(1'b1, 1'b0, BCC_OFS_CTRL, b ? 32'h0000_8000 : 32'h0000_0000);
      fc_n = 0;
      repeat (5) pulse(0);
      repeat (2) @(negedge clk);
      chk(fc_n, b ? 5 : 2);
    end
    $display("test flow done");
    for (int c = 1; c < 5; c++) begin
      int k;
      k = c % 4;
      io(1'b1, 1'b0, BCC_OFS_CTRL, {13'h0, k[1:0], 17'h0});
      // early retries wiped by a clear must not count toward the limit
      if (k == 2) begin
        repeat (3) pulse(1);
        pulse(5);
      end
      rx_n = 0;
      repeat (rl[k] - 1) pulse(1);
      chk(rx_n, 0);
      pulse(1);
      @(negedge clk);
      chk(rx_n, k ? 1 : 0);
      io(1'b0, 1'b0, BCC_OFS_CTRL, 32'h0);
      chk({31'h0, r[16]}, {31'h0, k != 0});
      io(1'b1, 1'b0, BCC_OFS_CTRL, r & 32'hfffe_ffff);
      io(1'b0, 1'b0, BCC_OFS_CTRL, 32'h0);
      chk({31'h0, r[16]}, {31'h0, k != 0});
      io(1'b1, 1'b0, BCC_OFS_CTRL, r | 32'h0001_0000);
      io(1'b0, 1'b0, BCC_OFS_CTRL, 32'h0);
      chk({31'h0, r[16]}, 32'h0);
    end
    $display("test retry done");
    io(1'b1, 1'b0, BCC_OFS_CTRL, 32'h8000_0000);
    io(1'b1, 1'b1, BCC_OFS_CTRL, 32'h0);
    chk({30'h0, s.ack, s.crs}, 32'h3);
    io(1'b0, 1'b1, BCC_OFS_CTRL, 32'h0);
    chk({30'h0, s.ack, s.crs}, 32'h3);
    chk(s.rdata, 32'h0);
    io(1'b0, 1'b0, BCC_OFS_CTRL, 32'h0);
    chk(r, 32'h8000_0000);
    $display("test lockout done");
    io(1'b1, 1'b0, BCC_OFS_CTRL, 32'h0010_0000);
    time_it(0, BCC_DISC_SHORT_PCLK, 1);
    io(1'b1, 1'b0, BCC_OFS_CTRL, 32'h0);
    time_it(0, 8, 1);
    bshort = 1'b1;
    time_it(0, 4, 1);
    bshort = 1'b0;
    io(1'b1, 1'b0, BCC_OFS_CTRL, 32'h0008_0000);
    time_it(0, 0, 1);
    io(1'b1, 1'b0, BCC_OFS_CTRL, 32'h0);
    bdis = 1'b1;
    time_it(0, 0, 1);
    bdis = 1'b0;
    for (int c = 0; c < 4; c++) begin
      io(1'b1, 1'b0, BCC_OFS_CTRL, {6'h0, c[1:0], 1'b0, c[1:0], 21'h0});
      time_it(1, crs_l[c], BCC_CYC_PER_US);
      time_it(2, cpl_l[c], BCC_CYC_PER_US);
    end
    // timers stopped after start must stay silent
    io(1'b1, 1'b0, BCC_OFS_CTRL, 32'h0);
    pulse(3);
    pulse(4);
    pulse(6);
    xp_n = 0;
    repeat (5200) @(negedge clk);
    chk(xp_n, 0);
    $display("test timers done");
    stop_test();
  end
endmodule : bcc_chip_ctrl_tb_top
`default_nettype wire
